// ### tpg_params.svh
// Purpose: Offsets, fields and reset values of the GPIO bank
// Assumes: 32-bit AXI4-Lite, one aligned word per register
// Notes: Narrow registers sit in the low byte
// Function
// [RL1] Port 1 direction 1 output, 0 input
// [RL2] Port 1 direction bits 7,4 only, reset 0
// [RL3] Port 1 direction bits act independently
// [RL4] Port 1 data latch bits 7,4 drive outputs
// [RL5] Port 1 output bit reads latch value
// [RL6] Port 1 input bit reads pin level
// [RL7] Port 1 reserved data/pullup bits read 1
// [RL8] Port 1 pull-up only on input pins
// [RL9] Port 1 pull-up bits 7,4 read/write, reset 0
// [RL10] Select bit 7 routes pin to ext_interrupt_three/trigger
// [RL11] Select bit 4 routes pin to ext_interrupt_zero
// [RL12] Port 2 select and serial override registers
// [RL13] Port 2 direction bits 2..0, reset 0
// [RL14] Port 2 direction bits independent, 7..3 reserved
// [RL15] Port 2 data latch bits 2..0 drive outputs
// [RL16] Port 2 output bit reads latch value
// [RL17] Port 2 input bit reads pin level
// [RL18] Port 2 reserved data bits read 1
// [RL19] Select bits 7,4 choose irq pins, reset 0
// [RL20] Select bit 1 makes pin two transmit
// [RL21] Data writes update latch while input
`ifndef TPG_PARAMS_SVH
`define TPG_PARAMS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define TPG_OFS_P1_DIR 8'h00
`define TPG_OFS_P1_DATA 8'h04
`define TPG_OFS_P1_PULL 8'h08
`define TPG_OFS_P2_DIR 8'h0C
`define TPG_OFS_P2_DATA 8'h10
`define TPG_OFS_FSEL 8'h14
`define TPG_OFS_SER_CTRL 8'h18

// ------------------------------------------------------------
// Field positions and masks
// ------------------------------------------------------------
`define TPG_P1_MASK 8'h90
`define TPG_P2_MASK 8'h07
`define TPG_FSEL_MASK 8'h92
`define TPG_BIT_SEVEN 7
`define TPG_BIT_FOUR 4
`define TPG_BIT_TXD 1
`define TPG_SER_RX_BIT 0
`define TPG_SER_CLK_BIT 1
`define TPG_SER_MASK 8'h03

// ------------------------------------------------------------
// Reset and reserved values
// ------------------------------------------------------------
`define TPG_P1_RSV_ONES 8'h6F
`define TPG_P2_RSV_ONES 8'hF8
`define TPG_RESET_ZERO 8'h00
`define TPG_RESP_OKAY 2'b00
`define TPG_RESP_SLVERR 2'b10

`endif

// ### tpg_pkg.sv
// Purpose: Types shared by the two-port GPIO bank
// Assumes: tpg_params.svh supplies the numeric constants
// Notes: Pin groups travel as packed structs
package tpg_pkg;
    // Three-signal pin bundle per port
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pull;
    } tpg_pin_drive_s;

    typedef enum logic [2:0] {
        TPG_RD_IDLE = 3'b001,
        TPG_RD_RESP = 3'b010,
        TPG_RD_HOLD = 3'b100
    } tpg_rd_state_e;

    typedef logic [7:0] tpg_byte_t;
endpackage

// ### tpg_pin_cell.sv
// Purpose: One general pin: direction, latch drive, pull-up and read-back mux
// Assumes: Pin input synchronous to the system clock
// Notes: Pure combinational; registers live in the top
`timescale 1ns/1ps
module tpg_pin_cell (
    input wire logic dir_in,
    input wire logic latch_in,
    input wire logic pull_en_in,
    input wire logic periph_in,
    input wire logic periph_out_in,
    input wire logic periph_oe_in,
    input wire logic pin_in,
    output logic oe_out,
    output logic out_out,
    output logic pull_out,
    output logic read_out
);
    always_comb begin
        // Peripheral selection overrides the direction bit
        if (periph_in) begin // RL10 RL11 RL12
            oe_out = periph_oe_in;
            out_out = periph_out_in;
        end else begin
            oe_out = dir_in; // RL1 RL13
            out_out = latch_in; // RL4 RL15
        end
        pull_out = pull_en_in & ~oe_out; // RL8
        read_out = dir_in ? latch_in : pin_in; // RL5 RL6 RL16 RL17
    end
endmodule // tpg_pin_cell

// ### tpg_gpio_bank.sv
// Purpose: Two-port GPIO bank with AXI4-Lite register access
// Assumes: Single clock, synchronous active-low reset, pins synchronous to clock
// Notes: Direction registers are write-only and read back as zero
`include "tpg_params.svh"
`timescale 1ns/1ps
module tpg_gpio_bank #(
    parameter int ADDR_W = 8
) (
    input wire logic SYS_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic CLK_EN_IN,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR_IN,
    input wire logic S_AXI_AWVALID_IN,
    output logic S_AXI_AWREADY_OUT,
    input wire logic [31:0] S_AXI_WDATA_IN,
    input wire logic [3:0] S_AXI_WSTRB_IN,
    input wire logic S_AXI_WVALID_IN,
    output logic S_AXI_WREADY_OUT,
    output logic [1:0] S_AXI_BRESP_OUT,
    output logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    output logic S_AXI_ARREADY_OUT,
    output logic [31:0] S_AXI_RDATA_OUT,
    output logic [1:0] S_AXI_RRESP_OUT,
    output logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    // Port 1 pins (bits 7 and 4 used)
    input wire logic [7:0] P1_PIN_IN,
    output logic [7:0] P1_PIN_OUT,
    output logic [7:0] P1_PIN_OE_OUT,
    output logic [7:0] P1_PULLUP_OUT,
    // Port 2 pins (bits 2..0 used)
    input wire logic [2:0] P2_PIN_IN,
    output logic [2:0] P2_PIN_OUT,
    output logic [2:0] P2_PIN_OE_OUT,
    // Peripheral hooks
    output logic EXT_INTERRUPT_THREE_OUT,
    output logic TIMER_TRIGGER_INPUT_OUT,
    output logic EXT_INTERRUPT_ZERO_OUT,
    input wire logic SERIAL_TXD_IN,
    output logic SERIAL_RXD_OUT,
    input wire logic SERIAL_CLK_OUT_IN,
    input wire logic SERIAL_CLK_OE_IN,
    output logic SERIAL_CLK_IN_OUT
);
    import tpg_pkg::*;

    initial begin
        if (ADDR_W < 5 || ADDR_W > 32) begin
            $error("ADDR_W must be 5 to 32");
        end
    end

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    tpg_byte_t p1_dir_reg;
    tpg_byte_t p1_data_reg;
    tpg_byte_t p1_pull_reg;
    tpg_byte_t p2_dir_reg;
    tpg_byte_t p2_data_reg;
    tpg_byte_t fsel_reg;
    tpg_byte_t ser_ctrl_reg;

    logic aw_held_reg;
    logic w_held_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    tpg_rd_state_e rd_state_reg;

    // ------------------------------------------------------------
    // Write channel: address and data accepted in either order
    // ------------------------------------------------------------
    logic aw_fire;
    logic w_fire;
    logic wr_go;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic wr_lane0;
    logic wr_ok;

    assign aw_fire = S_AXI_AWVALID_IN & S_AXI_AWREADY_OUT;
    assign w_fire = S_AXI_WVALID_IN & S_AXI_WREADY_OUT;
    assign wr_go = CLK_EN_IN & (aw_held_reg | aw_fire) & (w_held_reg | w_fire) & ~S_AXI_BVALID_OUT;
    assign wr_addr = aw_held_reg ? aw_addr_reg : S_AXI_AWADDR_IN;
    assign wr_data = w_held_reg ? w_data_reg : S_AXI_WDATA_IN;
    assign wr_lane0 = w_held_reg ? w_strb_reg[0] : S_AXI_WSTRB_IN[0];
    assign wr_ok = (wr_addr[1:0] == 2'b00) && (wr_addr[ADDR_W-1:2] <= ADDR_W'(`TPG_OFS_SER_CTRL) >> 2);

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        hit = (a == ADDR_W'(ofs));
    endfunction

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            S_AXI_AWREADY_OUT <= 1'b0;
            S_AXI_WREADY_OUT <= 1'b0;
            S_AXI_BVALID_OUT <= 1'b0;
            S_AXI_BRESP_OUT <= `TPG_RESP_OKAY;
        end else if (CLK_EN_IN) begin
            if (wr_go) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                S_AXI_BVALID_OUT <= 1'b1;
                S_AXI_BRESP_OUT <= wr_ok ? `TPG_RESP_OKAY : `TPG_RESP_SLVERR;
            end else begin
                if (aw_fire) begin
                    aw_held_reg <= 1'b1;
                    aw_addr_reg <= S_AXI_AWADDR_IN;
                end
                if (w_fire) begin
                    w_held_reg <= 1'b1;
                    w_data_reg <= S_AXI_WDATA_IN;
                    w_strb_reg <= S_AXI_WSTRB_IN;
                end
                if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
                    S_AXI_BVALID_OUT <= 1'b0;
                end
            end
            // Ready only while the channel slot is empty and no response pending
            S_AXI_AWREADY_OUT <= ~S_AXI_AWREADY_OUT & ~(aw_held_reg | aw_fire) & ~wr_go
                & ~S_AXI_BVALID_OUT;
            S_AXI_WREADY_OUT <= ~S_AXI_WREADY_OUT & ~(w_held_reg | w_fire) & ~wr_go
                & ~S_AXI_BVALID_OUT;
        end
    end

    // ------------------------------------------------------------
    // Register writes (byte lane 0 only carries implemented bits)
    // ------------------------------------------------------------
    logic wr_lane;
    assign wr_lane = wr_go & wr_ok & wr_lane0;

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            p1_dir_reg <= `TPG_RESET_ZERO; // RL2
            p2_dir_reg <= `TPG_RESET_ZERO; // RL13
        end else if (wr_lane) begin
            if (hit(wr_addr, `TPG_OFS_P1_DIR)) begin
                p1_dir_reg <= wr_data[7:0] & `TPG_P1_MASK; // RL2 RL3
            end
            if (hit(wr_addr, `TPG_OFS_P2_DIR)) begin
                p2_dir_reg <= wr_data[7:0] & `TPG_P2_MASK; // RL14
            end
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            p1_data_reg <= `TPG_RESET_ZERO; // RL4
            p2_data_reg <= `TPG_RESET_ZERO; // RL15
        end else if (wr_lane) begin
            // Latch is written whatever the direction, ready for a later switch
            if (hit(wr_addr, `TPG_OFS_P1_DATA)) begin
                p1_data_reg <= wr_data[7:0] & `TPG_P1_MASK; // RL21
            end
            if (hit(wr_addr, `TPG_OFS_P2_DATA)) begin
                p2_data_reg <= wr_data[7:0] & `TPG_P2_MASK; // RL21
            end
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            p1_pull_reg <= `TPG_RESET_ZERO; // RL9
            fsel_reg <= `TPG_RESET_ZERO; // RL19 RL20
            ser_ctrl_reg <= `TPG_RESET_ZERO;
        end else if (wr_lane) begin
            if (hit(wr_addr, `TPG_OFS_P1_PULL)) begin
                p1_pull_reg <= wr_data[7:0] & `TPG_P1_MASK; // RL9
            end
            if (hit(wr_addr, `TPG_OFS_FSEL)) begin
                fsel_reg <= wr_data[7:0] & `TPG_FSEL_MASK; // RL19
            end
            if (hit(wr_addr, `TPG_OFS_SER_CTRL)) begin
                ser_ctrl_reg <= wr_data[7:0] & `TPG_SER_MASK;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin cells
    // ------------------------------------------------------------
    tpg_pin_drive_s p1_drive;
    tpg_byte_t p1_read;
    logic [2:0] p2_oe;
    logic [2:0] p2_out;
    logic [2:0] p2_read;
    logic [2:0] p2_periph;
    logic [2:0] p2_periph_out;
    logic [2:0] p2_periph_oe;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_p1
            if (gi == `TPG_BIT_SEVEN || gi == `TPG_BIT_FOUR) begin : g_used
                tpg_pin_cell u_cell (
                    .dir_in(p1_dir_reg[gi]),
                    .latch_in(p1_data_reg[gi]),
                    .pull_en_in(p1_pull_reg[gi]),
                    .periph_in(fsel_reg[gi]), // RL10 RL11
                    .periph_out_in(1'b0),
                    .periph_oe_in(1'b0),
                    .pin_in(P1_PIN_IN[gi]),
                    .oe_out(p1_drive.oe[gi]),
                    .out_out(p1_drive.out[gi]),
                    .pull_out(p1_drive.pull[gi]),
                    .read_out(p1_read[gi])
                );
            end else begin : g_rsv
                assign p1_drive.oe[gi] = 1'b0;
                assign p1_drive.out[gi] = 1'b0;
                assign p1_drive.pull[gi] = 1'b0;
                assign p1_read[gi] = 1'b1; // RL7
            end
        end
    endgenerate

    // Serial settings win over the port registers on port 2
    assign p2_periph = {fsel_reg[`TPG_BIT_TXD], ser_ctrl_reg[`TPG_SER_RX_BIT],
        ser_ctrl_reg[`TPG_SER_CLK_BIT]}; // RL12 RL20
    assign p2_periph_out = {SERIAL_TXD_IN, 1'b0, SERIAL_CLK_OUT_IN};
    assign p2_periph_oe = {1'b1, 1'b0, SERIAL_CLK_OE_IN};

    generate
        for (gi = 0; gi < 3; gi++) begin : g_p2
            tpg_pin_cell u_cell (
                .dir_in(p2_dir_reg[gi]),
                .latch_in(p2_data_reg[gi]),
                .pull_en_in(1'b0),
                .periph_in(p2_periph[gi]),
                .periph_out_in(p2_periph_out[gi]),
                .periph_oe_in(p2_periph_oe[gi]),
                .pin_in(P2_PIN_IN[gi]),
                .oe_out(p2_oe[gi]),
                .out_out(p2_out[gi]),
                .pull_out(),
                .read_out(p2_read[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Registered pin and peripheral outputs
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            P1_PIN_OUT <= 8'h00;
            P1_PIN_OE_OUT <= 8'h00;
            P1_PULLUP_OUT <= 8'h00;
            P2_PIN_OUT <= 3'h0;
            P2_PIN_OE_OUT <= 3'h0;
            EXT_INTERRUPT_THREE_OUT <= 1'b0;
            TIMER_TRIGGER_INPUT_OUT <= 1'b0;
            EXT_INTERRUPT_ZERO_OUT <= 1'b0;
            SERIAL_RXD_OUT <= 1'b1;
            SERIAL_CLK_IN_OUT <= 1'b0;
        end else if (CLK_EN_IN) begin
            P1_PIN_OUT <= p1_drive.out; // RL4
            P1_PIN_OE_OUT <= p1_drive.oe; // RL1
            P1_PULLUP_OUT <= p1_drive.pull; // RL8
            P2_PIN_OUT <= p2_out; // RL15
            P2_PIN_OE_OUT <= p2_oe; // RL13
            // Unselected interrupt and trigger inputs idle low, receive idles high; serial clock input always follows pin 0
            EXT_INTERRUPT_THREE_OUT <= fsel_reg[`TPG_BIT_SEVEN] & P1_PIN_IN[7]; // RL10
            TIMER_TRIGGER_INPUT_OUT <= fsel_reg[`TPG_BIT_SEVEN] & P1_PIN_IN[7]; // RL10
            EXT_INTERRUPT_ZERO_OUT <= fsel_reg[`TPG_BIT_FOUR] & P1_PIN_IN[4]; // RL11
            SERIAL_RXD_OUT <= ser_ctrl_reg[`TPG_SER_RX_BIT] ? P2_PIN_IN[1] : 1'b1; // RL12
            SERIAL_CLK_IN_OUT <= P2_PIN_IN[0];
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    tpg_byte_t rd_byte;
    logic rd_ok;

    always_comb begin
        rd_byte = 8'h00;
        rd_ok = 1'b1;
        unique case (S_AXI_ARADDR_IN)
            ADDR_W'(`TPG_OFS_P1_DIR): rd_byte = 8'h00;
            ADDR_W'(`TPG_OFS_P1_DATA): rd_byte = p1_read; // RL5 RL6 RL7
            ADDR_W'(`TPG_OFS_P1_PULL): rd_byte = p1_pull_reg | `TPG_P1_RSV_ONES; // RL7
            ADDR_W'(`TPG_OFS_P2_DIR): rd_byte = 8'h00;
            ADDR_W'(`TPG_OFS_P2_DATA): rd_byte = {5'h1F, p2_read}; // RL16 RL17 RL18
            ADDR_W'(`TPG_OFS_FSEL): rd_byte = fsel_reg;
            ADDR_W'(`TPG_OFS_SER_CTRL): rd_byte = ser_ctrl_reg;
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            rd_state_reg <= TPG_RD_IDLE;
            S_AXI_ARREADY_OUT <= 1'b0;
            S_AXI_RVALID_OUT <= 1'b0;
            S_AXI_RDATA_OUT <= 32'h0000_0000;
            S_AXI_RRESP_OUT <= `TPG_RESP_OKAY;
        end else if (CLK_EN_IN) begin
            unique case (rd_state_reg)
                TPG_RD_IDLE: begin
                    S_AXI_ARREADY_OUT <= 1'b1;
                    if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
                        S_AXI_ARREADY_OUT <= 1'b0;
                        S_AXI_RVALID_OUT <= 1'b1;
                        S_AXI_RDATA_OUT <= {24'h00_0000, rd_byte};
                        S_AXI_RRESP_OUT <= rd_ok ? `TPG_RESP_OKAY : `TPG_RESP_SLVERR;
                        rd_state_reg <= TPG_RD_RESP;
                    end
                end
                TPG_RD_RESP: begin
                    if (S_AXI_RREADY_IN) begin
                        S_AXI_RVALID_OUT <= 1'b0;
                        rd_state_reg <= TPG_RD_HOLD;
                    end
                end
                TPG_RD_HOLD: begin
                    S_AXI_ARREADY_OUT <= 1'b1;
                    rd_state_reg <= TPG_RD_IDLE;
                end
                default: rd_state_reg <= TPG_RD_IDLE;
            endcase
        end
    end
endmodule // tpg_gpio_bank

// ### tpg_gpio_bank_assertions.sv
// Purpose: Port-level checks for the two-port GPIO bank
// Assumes: CLK_EN_IN high during pin checks
// Notes: Bound to every top instance
`include "tpg_params.svh"
`timescale 1ns/1ps
module tpg_gpio_bank_assertions #(
    parameter int ADDR_W = 8
) (
    input wire logic SYS_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    input wire logic S_AXI_ARREADY_OUT,
    input wire logic [31:0] S_AXI_RDATA_OUT,
    input wire logic [1:0] S_AXI_RRESP_OUT,
    input wire logic S_AXI_RVALID_OUT,
    input wire logic [7:0] P1_PIN_IN,
    input wire logic [7:0] P1_PIN_OE_OUT,
    input wire logic [7:0] P1_PULLUP_OUT,
    input wire logic [2:0] P2_PIN_OE_OUT,
    input wire logic EXT_INTERRUPT_THREE_OUT,
    input wire logic TIMER_TRIGGER_INPUT_OUT,
    input wire logic EXT_INTERRUPT_ZERO_OUT
);
    import tpg_pkg::*;
    logic [ADDR_W-1:0] rd_addr_reg;
    logic rd_okay;
    // ------------------------------------------------------------
    // Address of the read in flight
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            rd_addr_reg <= '1;
        end else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
            rd_addr_reg <= S_AXI_ARADDR_IN;
        end
    end
    assign rd_okay = S_AXI_RVALID_OUT && (S_AXI_RRESP_OUT == `TPG_RESP_OKAY);
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    p1_rsv_read_a: assert property (
        rd_okay && (rd_addr_reg == `TPG_OFS_P1_DATA || rd_addr_reg == `TPG_OFS_P1_PULL)
        |-> (S_AXI_RDATA_OUT[7:0] & `TPG_P1_RSV_ONES) == `TPG_P1_RSV_ONES)
        else $error("port 1 reserved bits not read as ones");
    p2_rsv_read_a: assert property (
        rd_okay && rd_addr_reg == `TPG_OFS_P2_DATA
        |-> (S_AXI_RDATA_OUT[7:0] & `TPG_P2_RSV_ONES) == `TPG_P2_RSV_ONES)
        else $error("port 2 reserved bits not read as ones");
    pull_off_out_a: assert property (
        (P1_PULLUP_OUT & P1_PIN_OE_OUT) == 8'h00)
        else $error("pull-up on while pin drives");
    unused_pins_a: assert property (
        ((P1_PIN_OE_OUT | P1_PULLUP_OUT) & `TPG_P1_RSV_ONES) == 8'h00)
        else $error("unused port 1 pin enabled");
    reset_inputs_a: assert property (
        $rose(RST_N_IN) |-> P1_PIN_OE_OUT == 8'h00 && P2_PIN_OE_OUT == 3'h0
        && P1_PULLUP_OUT == 8'h00)
        else $error("pins not inputs after reset");
    irq_three_pin_a: assert property (
        EXT_INTERRUPT_THREE_OUT |-> $past(P1_PIN_IN[7]))
        else $error("interrupt three without pin level");
    trigger_pair_a: assert property (
        TIMER_TRIGGER_INPUT_OUT == EXT_INTERRUPT_THREE_OUT)
        else $error("trigger and interrupt three differ");
    irq_zero_pin_a: assert property (
        $rose(EXT_INTERRUPT_ZERO_OUT) |-> $past(P1_PIN_IN[4]) ##1 1)
        else $error("interrupt zero without pin level");
endmodule // tpg_gpio_bank_assertions

bind tpg_gpio_bank tpg_gpio_bank_assertions #(.ADDR_W(ADDR_W)) u_tpg_gpio_bank_assertions (
    .SYS_CLK_IN, .RST_N_IN, .S_AXI_ARADDR_IN, .S_AXI_ARVALID_IN, .S_AXI_ARREADY_OUT,
    .S_AXI_RDATA_OUT, .S_AXI_RRESP_OUT, .S_AXI_RVALID_OUT, .P1_PIN_IN, .P1_PIN_OE_OUT,
    .P1_PULLUP_OUT, .P2_PIN_OE_OUT, .EXT_INTERRUPT_THREE_OUT, .TIMER_TRIGGER_INPUT_OUT,
    .EXT_INTERRUPT_ZERO_OUT);

// ### tpg_pin_model.sv
// Purpose: Outside circuitry on the port pins
// Assumes: Outside oe high means an outside driver is on
// Notes: An undriven, unpulled line toggles each cycle
`timescale 1ns/1ps
module tpg_pin_model (
    input wire logic SYS_CLK_IN,
    input wire tpg_pkg::tpg_pin_drive_s p1_dev_in,
    input wire tpg_pkg::tpg_pin_drive_s p2_dev_in,
    input wire tpg_pkg::tpg_pin_drive_s p1_ext_in,
    input wire tpg_pkg::tpg_pin_drive_s p2_ext_in,
    output logic [7:0] p1_pin_out,
    output logic [2:0] p2_pin_out
);
    import tpg_pkg::*;
    logic float_reg = 1'b0;
    logic [7:0] p2_all;
    always_ff @(posedge SYS_CLK_IN) begin
        float_reg <= !float_reg;
    end
    // Device drive wins, then the outside driver, then the pull-up
    function automatic logic [7:0] level(tpg_pin_drive_s dev, tpg_pin_drive_s ext, logic fl);
        return (dev.oe & dev.out) | (~dev.oe & ext.oe & ext.out)
            | (~dev.oe & ~ext.oe & (dev.pull | {8{fl}}));
    endfunction
    assign p1_pin_out = level(p1_dev_in, p1_ext_in, float_reg);
    assign p2_all = level(p2_dev_in, p2_ext_in, float_reg);
    assign p2_pin_out = p2_all[2:0];
endmodule // tpg_pin_model

// ### tb_tpg_gpio_bank.sv
// Purpose: Register-level tests of the two-port GPIO bank
// Assumes: Clock enable and strobes on
// Notes: Pin checks wait for registered outputs
`include "tpg_params.svh"
`timescale 1ns/1ps
module tb_tpg_gpio_bank;
    import tpg_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, txd = 1'b0;
    logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
    logic [7:0] aw_addr = 8'h00, ar_addr = 8'h00;
    logic [31:0] w_data = 32'h0000_0000, rdata, d;
    logic aw_ready, w_ready, bvalid, ar_ready, rvalid, ext_interrupt_three, trg, ext_interrupt_zero, rxd;
    logic [1:0] bresp, rresp, r;
    logic [7:0] p1_in, p1_out, p1_oe, p1_pull;
    logic [2:0] p2_in, p2_out, p2_oe;
    tpg_pin_drive_s p1_dev, p2_dev, p1_ext = '0, p2_ext = '0;
    int failures = 0, n_compared = 0;
    assign p1_dev = {p1_out, p1_oe, p1_pull};
    assign p2_dev = {5'h00, p2_out, 5'h00, p2_oe, 8'h00};
    tpg_gpio_bank #(.ADDR_W(8)) u_tpg_gpio_bank (.SYS_CLK_IN(clk), .RST_N_IN(rst_n),
        .CLK_EN_IN(1'b1), .S_AXI_AWADDR_IN(aw_addr), .S_AXI_AWVALID_IN(aw_valid),
        .S_AXI_AWREADY_OUT(aw_ready), .S_AXI_WDATA_IN(w_data), .S_AXI_WSTRB_IN(4'hF),
        .S_AXI_WVALID_IN(w_valid), .S_AXI_WREADY_OUT(w_ready), .S_AXI_BRESP_OUT(bresp),
        .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(b_ready), .S_AXI_ARADDR_IN(ar_addr),
        .S_AXI_ARVALID_IN(ar_valid), .S_AXI_ARREADY_OUT(ar_ready), .S_AXI_RDATA_OUT(rdata),
        .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(r_ready),
        .P1_PIN_IN(p1_in), .P1_PIN_OUT(p1_out), .P1_PIN_OE_OUT(p1_oe),
        .P1_PULLUP_OUT(p1_pull), .P2_PIN_IN(p2_in), .P2_PIN_OUT(p2_out),
        .P2_PIN_OE_OUT(p2_oe), .EXT_INTERRUPT_THREE_OUT(ext_interrupt_three), .TIMER_TRIGGER_INPUT_OUT(trg),
        .EXT_INTERRUPT_ZERO_OUT(ext_interrupt_zero), .SERIAL_TXD_IN(txd), .SERIAL_RXD_OUT(rxd),
        .SERIAL_CLK_OUT_IN(1'b0), .SERIAL_CLK_OE_IN(1'b0), .SERIAL_CLK_IN_OUT());
    tpg_pin_model u_tpg_pin_model (.SYS_CLK_IN(clk), .p1_dev_in(p1_dev), .p2_dev_in(p2_dev),
        .p1_ext_in(p1_ext), .p2_ext_in(p2_ext), .p1_pin_out(p1_in), .p2_pin_out(p2_in));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
        int n = 0;
        @(posedge clk);
        aw_addr <= a;
        w_data <= {24'h00_0000, v};
        aw_valid <= 1'b1;
        w_valid <= 1'b1;
        b_ready <= 1'b1;
        while (n < 200) begin
            @(posedge clk);
            n++;
            if (aw_ready) aw_valid <= 1'b0;
            if (w_ready) w_valid <= 1'b0;
            if (bvalid) begin
                b_ready <= 1'b0;
                chk(32'(bresp), 32'(er));
                break;
            end
        end
        if (n >= 200) failures++;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        int n = 0;
        v = '0;
        rs = 2'b11;
        @(posedge clk);
        ar_addr <= a;
        ar_valid <= 1'b1;
        r_ready <= 1'b1;
        while (n < 200) begin
            @(posedge clk);
            n++;
            if (ar_ready) ar_valid <= 1'b0;
            if (rvalid) begin
                v = rdata;
                rs = rresp;
                r_ready <= 1'b0;
                break;
            end
        end
        if (n >= 200) failures++;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] v;
        logic [1:0] rs;
        rd(a, v, rs);
        chk(v, {24'h00_0000, e});
        chk(32'(rs), 32'(`TPG_RESP_OKAY));
    endtask
    // Outside drivers, then settle
    task automatic drive(input logic [7:0] e1, v1, input logic [2:0] e2, v2);
        @(posedge clk);
        p1_ext.oe <= e1;
        p1_ext.out <= v1;
        p2_ext.oe <= {5'h00, e2};
        p2_ext.out <= {5'h00, v2};
        repeat (3) @(posedge clk);
    endtask
    initial begin
        #80000;
        failures++;
        summarize();
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        drive(8'h90, 8'h80, 3'h7, 3'h5);
        chk(32'(p1_oe), 32'h0);
        chk(32'(p2_oe), 32'h0);
        rchk(`TPG_OFS_P1_DATA, 8'hEF);
        rchk(`TPG_OFS_P1_PULL, 8'h6F);
        rchk(`TPG_OFS_P2_DATA, 8'hFD);
        rchk(`TPG_OFS_P1_DIR, 8'h00);
        wr(`TPG_OFS_P1_DATA, 8'h90, `TPG_RESP_OKAY);
        rchk(`TPG_OFS_P1_DATA, 8'hEF);
        wr(`TPG_OFS_P1_DIR, 8'h10, `TPG_RESP_OKAY);
        drive(8'h80, 8'h00, 3'h2, 3'h2);
        chk(32'(p1_oe), 32'h10);
        chk(32'(p1_out & 8'h10), 32'h10);
        rchk(`TPG_OFS_P1_DATA, 8'h7F);
        wr(`TPG_OFS_P1_PULL, 8'h90, `TPG_RESP_OKAY);
        drive(8'h00, 8'h00, 3'h2, 3'h2);
        chk(32'(p1_pull), 32'h80);
        rchk(`TPG_OFS_P1_PULL, 8'hFF);
        rchk(`TPG_OFS_P1_DATA, 8'hFF);
        wr(`TPG_OFS_P1_DIR, 8'h90, `TPG_RESP_OKAY);
        drive(8'h00, 8'h00, 3'h2, 3'h2);
        chk({p1_oe, p1_pull}, 32'h9000);
        wr(`TPG_OFS_FSEL, 8'h90, `TPG_RESP_OKAY);
        drive(8'h90, 8'h80, 3'h2, 3'h2);
        chk(32'(p1_oe), 32'h0);
        chk(32'({ext_interrupt_three, trg, ext_interrupt_zero}), 32'h6);
        drive(8'h90, 8'h10, 3'h2, 3'h2);
        chk(32'({ext_interrupt_three, trg, ext_interrupt_zero}), 32'h1);
        wr(`TPG_OFS_FSEL, 8'h00, `TPG_RESP_OKAY);
        wr(`TPG_OFS_P2_DIR, 8'h05, `TPG_RESP_OKAY);
        wr(`TPG_OFS_P2_DATA, 8'h06, `TPG_RESP_OKAY);
        drive(8'h00, 8'h00, 3'h2, 3'h2);
        chk(32'(p2_oe), 32'h5);
        chk(32'(p2_out & 3'h5), 32'h4);
        rchk(`TPG_OFS_P2_DATA, 8'hFE);
        rchk(`TPG_OFS_P2_DIR, 8'h00);
        wr(`TPG_OFS_FSEL, 8'h02, `TPG_RESP_OKAY);
        drive(8'h00, 8'h00, 3'h2, 3'h2);
        chk(32'({p2_oe[2], p2_out[2]}), 32'h2);
        txd <= 1'b1;
        drive(8'h00, 8'h00, 3'h2, 3'h2);
        chk(32'({p2_oe[2], p2_out[2]}), 32'h3);
        txd <= 1'b0;
        wr(`TPG_OFS_FSEL, 8'h00, `TPG_RESP_OKAY);
        drive(8'h00, 8'h00, 3'h2, 3'h2);
        chk(32'({p2_oe[2], p2_out[2]}), 32'h3);
        wr(`TPG_OFS_SER_CTRL, 8'h01, `TPG_RESP_OKAY);
        drive(8'h00, 8'h00, 3'h2, 3'h0);
        chk(32'(rxd), 32'h0);
        wr(8'h40, 8'hFF, `TPG_RESP_SLVERR);
        rd(8'h40, d, r);
        chk(d, 32'h0);
        chk(32'(r), 32'(`TPG_RESP_SLVERR));
        summarize();
    end
endmodule // tb_tpg_gpio_bank
